// File: hw/arp_pwm.sv
// Auto-reload timer with single PWM output stage
// How it works
// - Period follows counter clock and reload value
// - Reload value accepts any 12-bit value
// - Polarity 0: low above duty, else high
// - Polarity 1: high above duty, else low
// - Duty compare value is full 12 bits
// - Clearing enable returns to output compare
// - Output compare off while PWM runs
module arp_pwm
  import arp_pkg::*;
(
  input wire logic sys_clk, // 100 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire arp_cfg_t cfg, // Software configuration
  output arp_stat_t stat, // Counter and mode status
  output logic first_pulse_output_pin // PWM pin
);
  // Prescaler phase runs freely from reset
  logic [1:0] prescale;
  logic [1:0] next_prescale;
  // One enable per divider stage
  wire [ARP_DIV_STAGES-1:0] div_tick;

  // Counter and its shadowed compare value
  logic [ARP_W-1:0] count;
  logic [ARP_W-1:0] next_count;
  logic [ARP_W-1:0] step_value;
  logic [ARP_W-1:0] duty_active;
  logic [ARP_W-1:0] next_duty_active;

  // Pin and status flops
  logic pwm_out;
  logic next_pwm_out;
  logic compare_mode;
  logic next_compare_mode;
  logic reload_pulse;
  logic next_reload_pulse;

  // Decoded controls
  logic pwm_active;
  logic cnt_tick;
  logic at_max;
  logic reload_now;
  logic shadow_load;
  logic above;
  logic pwm_level;

  // Pick the divider stage that feeds the counter
  function automatic logic pick_tick(
    input arp_clksel_t sel,
    input logic [ARP_DIV_STAGES-1:0] ticks
  );
    logic t;
    t = 1'b0;
    unique case (sel)
      ARP_CLK_OFF: begin
        t = 1'b0;
      end
      ARP_CLK_DIV1: begin
        t = ticks[ARP_DIV1_STAGE];
      end
      ARP_CLK_DIV2: begin
        t = ticks[ARP_DIV2_STAGE];
      end
      ARP_CLK_DIV4: begin
        t = ticks[ARP_DIV4_STAGE];
      end
    endcase
    return t;
  endfunction : pick_tick

  // Counter has reached the top of its range
  function automatic logic is_max(
    input logic [ARP_W-1:0] value
  );
    return value == ARP_CNT_MAX;
  endfunction : is_max

  // Counter sits strictly above the compare value
  function automatic logic is_above(
    input logic [ARP_W-1:0] value,
    input logic [ARP_W-1:0] limit
  );
    return value > limit;
  endfunction : is_above

  // Pin level from compare result and polarity
  function automatic logic level_of(
    input logic cmp_above,
    input logic polarity
  );
    logic lvl;
    lvl = ~cmp_above;
    if (polarity) begin
      lvl = cmp_above;
    end
    return lvl;
  endfunction : level_of

  // Value the counter takes on its next tick
  function automatic logic [ARP_W-1:0] step_of(
    input logic [ARP_W-1:0] value,
    input logic [ARP_W-1:0] reload
  );
    logic [ARP_W-1:0] nxt;
    nxt = value + ARP_CNT_STEP;
    if (is_max(value)) begin
      nxt = reload;
    end
    return nxt;
  endfunction : step_of

  // Take a fresh value when asked, else keep the held one
  function automatic logic [ARP_W-1:0] take_if(
    input logic take,
    input logic [ARP_W-1:0] fresh,
    input logic [ARP_W-1:0] held
  );
    logic [ARP_W-1:0] v;
    v = held;
    if (take) begin
      v = fresh;
    end
    return v;
  endfunction : take_if

  // Stage k fires when the low k phase bits are all set
  assign div_tick[ARP_DIV1_STAGE] = 1'b1;
  for (genvar k = 1; k < ARP_DIV_STAGES; k++) begin : g_div
    assign div_tick[k] = &prescale[k-1:0];
  end

  assign next_prescale = prescale + ARP_PRE_STEP;

  // With no source selected the counter stays frozen
  assign cnt_tick = pick_tick(cfg.clk_sel, div_tick);
  assign at_max = is_max(count);
  assign reload_now = cnt_tick && at_max;
  assign step_value = step_of(count, cfg.reload_value);
  assign next_count = take_if(cnt_tick, step_value, count);

  // Shadow follows the setting while idle, else waits for a reload
  assign pwm_active = cfg.pwm_en;
  assign shadow_load = reload_now || !pwm_active;
  assign next_duty_active = take_if(shadow_load, cfg.duty,
                                    duty_active);
  assign above = is_above(count, duty_active);
  assign pwm_level = level_of(above, cfg.polarity);
  // Disabled pin rests at the inactive level of its polarity
  assign next_pwm_out = pwm_active ? pwm_level : cfg.polarity;
  assign next_compare_mode = ~pwm_active;
  assign next_reload_pulse = reload_now;

  // Prescaler keeps running while the counter is stopped, so a
  // restart may land on any phase of a divided clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prescale <= ARP_PRE_RST;
    end else begin
      prescale <= next_prescale;
    end
  end

  // Counter advances only on the selected tick
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= ARP_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // Shadowed duty avoids a cut-short period on mid-period writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      duty_active <= ARP_ZERO;
    end else begin
      duty_active <= next_duty_active;
    end
  end

  // One-cycle marker after each reload
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reload_pulse <= ARP_PULSE_RST;
    end else begin
      reload_pulse <= next_reload_pulse;
    end
  end

  // Pin is registered, one cycle behind the compare
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_out <= ARP_PIN_RST;
    end else begin
      pwm_out <= next_pwm_out;
    end
  end

  // Output compare comes back one cycle after PWM is switched off
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      compare_mode <= ARP_MODE_RST;
    end else begin
      compare_mode <= next_compare_mode;
    end
  end

  // Outputs come straight from the flops above
  assign first_pulse_output_pin = pwm_out;
  assign stat.count = count;
  assign stat.duty_active = duty_active;
  assign stat.compare_mode = compare_mode;
  assign stat.reload_pulse = reload_pulse;
endmodule : arp_pwm

// File: hw/arp_pkg.sv
// Package: constants and carrier types for the auto-reload PWM block
package arp_pkg;
  localparam int ARP_W = 12;
  localparam logic [11:0] ARP_CNT_MAX = 12'hfff;
  localparam logic [11:0] ARP_ZERO = 12'h000;
  localparam logic [1:0] ARP_PRE_RST = 2'h0;
  localparam logic [11:0] ARP_CNT_STEP = 12'h001;
  localparam logic [1:0] ARP_PRE_STEP = 2'h1;
  localparam logic ARP_PIN_RST = 1'b0;
  localparam logic ARP_MODE_RST = 1'b1;
  localparam logic ARP_PULSE_RST = 1'b0;
  // Divider stages: stage k ticks once every 2**k clocks
  localparam int ARP_DIV_STAGES = 3;
  localparam int ARP_DIV1_STAGE = 0;
  localparam int ARP_DIV2_STAGE = 1;
  localparam int ARP_DIV4_STAGE = 2;

  // Counter clock source selection
  typedef enum logic [1:0] {
    ARP_CLK_OFF = 2'b00,
    ARP_CLK_DIV1 = 2'b01,
    ARP_CLK_DIV2 = 2'b10,
    ARP_CLK_DIV4 = 2'b11
  } arp_clksel_t;

  typedef struct packed {
    arp_clksel_t clk_sel;
    logic pwm_en;
    logic polarity;
    logic [11:0] reload_value;
    logic [11:0] duty;
  } arp_cfg_t;

  typedef struct packed {
    logic [11:0] count;
    logic [11:0] duty_active;
    logic compare_mode;
    logic reload_pulse;
  } arp_stat_t;
endpackage : arp_pkg

// File: tb/arp_pwm_properties.sv
// Checker: cycle relations at the PWM block ports
module arp_chk import arp_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic resetn, // reset
  input wire arp_cfg_t cfg, // config
  input wire arp_stat_t stat, // status
  input wire logic first_pulse_output_pin // pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_pin_level: assert property ($past(cfg.pwm_en) |->
    first_pulse_output_pin == (($past(stat.count) > $past(stat.duty_active))
    ~^ $past(cfg.polarity))) else $error("pin level");
  chk_mode_flag: assert property (
    stat.compare_mode == !$past(cfg.pwm_en)) else $error("mode flag");
  chk_wrap_reload: assert property ($past(stat.count) == ARP_CNT_MAX &&
    $past(cfg.clk_sel) == ARP_CLK_DIV1 |->
    stat.count == $past(cfg.reload_value)) else $error("no reload");
  chk_count_frozen: assert property (
    $past(cfg.clk_sel) == ARP_CLK_OFF |-> $stable(stat.count))
    else $error("count moved with no clock source");
  chk_pulse_origin: assert property (
    stat.reload_pulse |-> $past(stat.count) == ARP_CNT_MAX)
    else $error("stray reload pulse");
  chk_duty_held: assert property (
    $past(cfg.pwm_en) && $past(stat.count) != ARP_CNT_MAX
    |-> $stable(stat.duty_active)) else $error("duty changed mid-period");
  chk_idle_level: assert property (
    $past(resetn) && !$past(cfg.pwm_en)
    |-> first_pulse_output_pin == $past(cfg.polarity))
    else $error("idle pin level");
endmodule : arp_chk
bind arp_pwm arp_chk chk_u (.sys_clk, .resetn, .cfg, .stat,
  .first_pulse_output_pin);

// File: tb/arp_pwm_tb.sv
// Bench for the PWM block
module arp_pwm_tb import arp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, resetn = 0, pin;
  arp_cfg_t cfg = '0;
  arp_stat_t stat;
  int error_cnt = 0, check_count = 0;
  arp_pwm dut_u (.sys_clk, .resetn, .cfg, .stat,
    .first_pulse_output_pin(pin));
  initial forever #5 sys_clk = ~sys_clk;
  task check(input logic [11:0] s, e);
    check_count++;
    if (s !== e) error_cnt++;
    if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
  endtask : check
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task pulse_gap(output int n);
    int i;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while (i < 200 && stat.reload_pulse !== 1'b1);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (n < 200 && stat.reload_pulse !== 1'b1);
  endtask : pulse_gap
  task run_period;
    // Clock source first, duty above reload keeps a waveform
    cfg = '{ARP_CLK_DIV1, 1'b1, 1'b1, 12'hfe0, 12'hff0};
    for (int i = 0; i < 5000 && stat.count !== 12'hfff; i++)
      @(negedge sys_clk);
    // The first reload brings in the shadowed duty
    @(negedge sys_clk);
    check(stat.count, 12'hfe0);
    check(stat.duty_active, 12'hff0);
    for (int i = 1; i < 32; i++) begin
      @(negedge sys_clk);
      // Mid-period duty write must wait for the next reload
      if (i == 4) cfg.duty = 12'hfe8;
      check(12'(pin), 12'(12'(12'hfe0 + i) > 12'hff1));
    end
    check(stat.duty_active, 12'hff0);
    check(12'(stat.compare_mode), 12'h000);
    cfg.pwm_en = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(12'(stat.compare_mode), 12'h001);
    check(12'(pin), 12'h001);
  endtask : run_period
  task run_pol_low;
    // Shadow loads while disabled, then PWM is switched on
    cfg = '{ARP_CLK_DIV1, 1'b0, 1'b0, 12'hff0, 12'hff8};
    @(negedge sys_clk);
    cfg.pwm_en = 1'b1;
    for (int i = 0; i < 100 && stat.count !== 12'hfff; i++)
      @(negedge sys_clk);
    @(negedge sys_clk);
    check(stat.count, 12'hff0);
    check(stat.duty_active, 12'hff8);
    for (int i = 1; i < 16; i++) begin
      @(negedge sys_clk);
      check(12'(pin), 12'(12'(12'hfef + i) <= 12'hff8));
    end
  endtask : run_pol_low
  task run_divider;
    int n;
    cfg.clk_sel = ARP_CLK_DIV2;
    pulse_gap(n);
    check(12'(n), 12'(2 * (12'hfff - 12'hff0 + 1)));
    cfg.clk_sel = ARP_CLK_DIV4;
    cfg.reload_value = 12'hffc;
    cfg.duty = 12'hffe;
    pulse_gap(n);
    check(12'(n), 12'(4 * (12'hfff - 12'hffc + 1)));
  endtask : run_divider
  task run_freeze;
    logic [11:0] held;
    cfg.clk_sel = ARP_CLK_OFF;
    @(negedge sys_clk);
    held = stat.count;
    repeat (8) @(negedge sys_clk);
    check(stat.count, held);
    cfg.clk_sel = ARP_CLK_DIV1;
    @(negedge sys_clk);
    check(stat.count, held == 12'hfff ? 12'hffc : held + 12'h001);
  endtask : run_freeze
  initial begin
    repeat (8) @(negedge sys_clk);
    resetn = 1;
    run_period;
    run_pol_low;
    run_divider;
    run_freeze;
    wrap_up;
  end
  initial begin
    #60us;
    error_cnt++;
    wrap_up;
  end
endmodule : arp_pwm_tb
